// File: core/slrs_top.sv
/*
 * slrs_top.sv: ramp step and link status registers with a small link
 * bring-up sequencer and the ramp pattern generator, apb slave.
 * assumes: pclk is the frame clock; sync_n, sysref_shift and clk_ready are
 * synchronous to pclk; one apb master.
 */
// How it works
// R01: step value is low byte at 0x62, high byte at 0x63.
// R02: software never writes a zero step value.
// R03: software clears serializer enable before changing the step bytes.
// R04: link flag bit 6 set after sync and ila done, data flowing.
// R05: sync flag bit 5 low on request and during sync, else one; the code also holds it low in SLRS_IDLE.
// R06: receiver holds sync request low for the minimum frame count.
// R07: sync flag follows the procedure state, not the raw pin.
// R08: clock_phase_shift_flag flag bit 4 set when sysref shifts frame clock phase.
// R09: writing one clears clock_phase_shift_flag flag, zero leaves it.
// R10: sysref without phase change leaves clock_phase_shift_flag flag alone.
// R11: clock_phase_shift_flag flag cleared while clock ready is low.
// R12: ramp encoding of test pattern select sends the ramp.
// R13: ramp sample rises by the step each sample, wraps at 65536.
// R14: status bit 7 reads zero and ignores writes.
`timescale 1ns/1ps
`default_nettype none
`include "slrs_cfg.svh"

module slrs_top
    import slrs_pkg::*;
#(
    parameter int SYNC_MIN = `SLRS_SYNC_MIN_FRAMES,
    parameter int CGS_LEN = `SLRS_CGS_FRAMES,
    parameter int ILA_LEN = `SLRS_ILA_FRAMES
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [`SLRS_ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic sync_n,
    input wire logic sysref_shift,
    input wire logic clk_ready,
    output logic serializer_enable,
    output logic [3:0] test_pattern_select,
    output logic [15:0] sample_out,
    output logic sample_valid,
    output logic irq
);

    // counters are eight bits wide, so longer counts cannot be served
    if (SYNC_MIN < 1 || SYNC_MIN > 255 || CGS_LEN < 1 || CGS_LEN > 255 ||
        ILA_LEN < 1 || ILA_LEN > 255) begin : g_bad_counts
        $error("slrs_top: counts must be 1..255");
    end

    ////////////////////////////////////////////////////////////////////////
    // apb decode: zero wait state, unmapped address answers pslverr
    logic acc;
    logic wr;
    logic rd;
    logic [7:0] idx;
    logic hit_lo, hit_hi, hit_st, hit_ctrl, hit_is, hit_im, hit_any;

    assign acc = psel && penable;
    assign wr = acc && pwrite && pstrb[0];
    assign rd = acc && !pwrite;
    assign idx = paddr[9:2];
    assign hit_lo = (paddr[1:0] == 2'h0) && (idx == `SLRS_IDX_RSTEP_LO);
    assign hit_hi = (paddr[1:0] == 2'h0) && (idx == `SLRS_IDX_RSTEP_HI);
    assign hit_st = (paddr[1:0] == 2'h0) && (idx == `SLRS_IDX_STATUS);
    assign hit_ctrl = (paddr[1:0] == 2'h0) && (idx == `SLRS_IDX_CTRL);
    assign hit_is = (paddr[1:0] == 2'h0) && (idx == `SLRS_IDX_IRQ_STAT);
    assign hit_im = (paddr[1:0] == 2'h0) && (idx == `SLRS_IDX_IRQ_MASK);
    assign hit_any = hit_lo || hit_hi || hit_st || hit_ctrl || hit_is || hit_im;
    assign pready = 1'b1;
    assign pslverr = acc && !hit_any;

    ////////////////////////////////////////////////////////////////////////
    // step and control registers
    logic [7:0] step_lo_reg;
    logic [7:0] step_hi_reg;
    logic [7:0] ctrl_reg;
    logic [15:0] ramp_step_value;

    // R01: two byte step
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step_lo_reg <= `SLRS_RST_STEP_LO;
            step_hi_reg <= `SLRS_RST_STEP_HI;
        end else begin
            if (wr && hit_lo) begin
                step_lo_reg <= pwdata[7:0];
            end
            if (wr && hit_hi) begin
                step_hi_reg <= pwdata[7:0];
            end
        end
    end
    assign ramp_step_value = {step_hi_reg, step_lo_reg};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= `SLRS_RST_CTRL;
        end else if (wr && hit_ctrl) begin
            ctrl_reg <= {pwdata[7:4], 3'h0, pwdata[0]};
        end
    end
    assign serializer_enable = ctrl_reg[`SLRS_CTRL_EN];
    assign test_pattern_select = ctrl_reg[`SLRS_CTRL_TM_LSB +: 4];

    ////////////////////////////////////////////////////////////////////////
    // link bring-up sequencer; relies on the receiver holding a real request
    slrs_link_e state_reg;
    logic [7:0] cnt_reg;
    logic [7:0] sync_cnt_reg;
    logic sync_req;

    // R06: request qualified only after the minimum low time
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_cnt_reg <= 8'h00;
        end else if (sync_n) begin
            sync_cnt_reg <= 8'h00;
        end else if (sync_cnt_reg != 8'(SYNC_MIN)) begin
            sync_cnt_reg <= sync_cnt_reg + 8'h01;
        end
    end
    assign sync_req = !sync_n && (sync_cnt_reg == 8'(SYNC_MIN) - 8'h01);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= SLRS_IDLE;
            cnt_reg <= 8'h00;
        end else if (!serializer_enable || !clk_ready) begin
            state_reg <= SLRS_IDLE;
            cnt_reg <= 8'h00;
        end else begin
            case (state_reg)
                SLRS_IDLE: begin
                    state_reg <= SLRS_CGS;
                    cnt_reg <= 8'h00;
                end
                SLRS_CGS: begin
                    // code groups go out until the receiver has released its request for CGS_LEN frames
                    if (!sync_n || cnt_reg != 8'(CGS_LEN - 1)) begin
                        cnt_reg <= sync_n ? cnt_reg + 8'h01 : 8'h00;
                    end else begin
                        state_reg <= SLRS_ILA;
                        cnt_reg <= 8'h00;
                    end
                end
                SLRS_ILA: begin
                    if (cnt_reg == 8'(ILA_LEN - 1)) begin
                        state_reg <= SLRS_DATA;
                    end
                    cnt_reg <= cnt_reg + 8'h01;
                end
                SLRS_DATA: begin
                    if (sync_req) begin
                        state_reg <= SLRS_CGS;
                        cnt_reg <= 8'h00;
                    end
                end
                default: begin
                    state_reg <= SLRS_IDLE;
                end
            endcase
        end
    end

    logic link_up;
    logic sync_flag;
    // R04: link flag only in data phase
    assign link_up = (state_reg == SLRS_DATA);
    // R05: low while synchronising or a request is qualified
    // R07: from the sequencer state, not the pin
    assign sync_flag = (state_reg == SLRS_ILA) || (state_reg == SLRS_DATA && !sync_req);

    ////////////////////////////////////////////////////////////////////////
    // clock_phase_shift_flag flag
    logic clock_phase_shift_flag_reg;
    logic clock_phase_shift_flag_wclr;
    assign clock_phase_shift_flag_wclr = wr && hit_st && pwdata[`SLRS_ST_CLOCK_PHASE_SHIFT_FLAG];

    // R08: set on phase shift; R10: plain sysref never reaches sysref_shift
    // R09: write one clears, set wins; R11: cleared without clock ready
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            clock_phase_shift_flag_reg <= 1'b0;
        end else if (!clk_ready) begin
            clock_phase_shift_flag_reg <= 1'b0;
        end else if (sysref_shift) begin
            clock_phase_shift_flag_reg <= 1'b1;
        end else if (clock_phase_shift_flag_wclr) begin
            clock_phase_shift_flag_reg <= 1'b0;
        end
    end

    logic [7:0] status_val;
    // R14: bit 7 constant zero
    assign status_val = {1'b0, link_up, sync_flag, clock_phase_shift_flag_reg, 4'h0};

    ////////////////////////////////////////////////////////////////////////
    // interrupts: bit0 link up, bit1 sync request, bit2 clock_phase_shift_flag; read clears
    logic [2:0] irq_stat_reg;
    logic [2:0] irq_mask_reg;
    logic [2:0] irq_ev;
    logic link_d_reg;
    logic sync_d_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            link_d_reg <= 1'b0;
            sync_d_reg <= 1'b0;
        end else begin
            link_d_reg <= link_up;
            sync_d_reg <= sync_req;
        end
    end
    assign irq_ev = {sysref_shift && clk_ready, sync_req && !sync_d_reg, link_up && !link_d_reg};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_reg <= 3'h0;
        end else if (rd && hit_is) begin
            irq_stat_reg <= irq_ev;
        end else begin
            irq_stat_reg <= irq_stat_reg | irq_ev;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_mask_reg <= 3'h0;
        end else if (wr && hit_im) begin
            irq_mask_reg <= pwdata[2:0];
        end
    end
    assign irq = |(irq_stat_reg & irq_mask_reg);

    ////////////////////////////////////////////////////////////////////////
    // read data, combinational in the access cycle
    always_comb begin
        prdata = 32'h0;
        if (rd) begin
            if (hit_lo) prdata = {24'h0, step_lo_reg};
            else if (hit_hi) prdata = {24'h0, step_hi_reg};
            else if (hit_st) prdata = {24'h0, status_val};
            else if (hit_ctrl) prdata = {24'h0, ctrl_reg};
            else if (hit_is) prdata = {29'h0, irq_stat_reg};
            else if (hit_im) prdata = {29'h0, irq_mask_reg};
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // ramp generator; step assumed nonzero and stable while enabled
    logic [15:0] ramp_reg;
    logic ramp_on;
    assign ramp_on = link_up && (test_pattern_select == `SLRS_TM_RAMP);

    // R12: ramp selected; R13: add step, wraps naturally at 16 bits
    // R02: zero step would freeze the ramp; R03: step held while enabled
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ramp_reg <= 16'h0000;
            sample_valid <= 1'b0;
        end else begin
            sample_valid <= ramp_on;
            if (ramp_on) begin
                ramp_reg <= ramp_reg + ramp_step_value;
            end else begin
                ramp_reg <= 16'h0000;
            end
        end
    end
    assign sample_out = ramp_reg;

    ////////////////////////////////////////////////////////////////////////
    // checks
    // R13: ramp step
    chk_ramp_step: assert property (@(posedge pclk) disable iff (!presetn) // R13
        ramp_on && $past(ramp_on) |-> ramp_reg == 16'($past(ramp_reg) + ramp_step_value))
        else $error("ramp did not advance by step");
    // R09: write one clears
    chk_clock_phase_shift_flag_clear: assert property (@(posedge pclk) disable iff (!presetn) // R09
        clock_phase_shift_flag_wclr && !sysref_shift |=> !clock_phase_shift_flag_reg)
        else $error("clock_phase_shift_flag not cleared by write");
    // R08: set on shift
    chk_clock_phase_shift_flag_set: assert property (@(posedge pclk) disable iff (!presetn) // R08
        sysref_shift && clk_ready |=> clock_phase_shift_flag_reg)
        else $error("clock_phase_shift_flag not set");
    // R11: clock ready loss
    chk_clock_phase_shift_flag_clkrdy: assert property (@(posedge pclk) disable iff (!presetn) // R11
        !clk_ready |=> !clock_phase_shift_flag_reg)
        else $error("clock_phase_shift_flag survived clock loss");
    // R10: no spurious set
    chk_clock_phase_shift_flag_hold: assert property (@(posedge pclk) disable iff (!presetn) // R10
        !clock_phase_shift_flag_reg && !sysref_shift |=> !clock_phase_shift_flag_reg)
        else $error("clock_phase_shift_flag set without shift");
    // R04: link only after ila
    chk_link_order: assert property (@(posedge pclk) disable iff (!presetn) // R04
        $rose(link_up) |-> $past(state_reg) == SLRS_ILA)
        else $error("link up without ila");
    // R05: sync flag low during sync
    chk_sync_flag: assert property (@(posedge pclk) disable iff (!presetn) // R05
        state_reg == SLRS_CGS |-> !status_val[`SLRS_ST_SYNC])
        else $error("sync flag high while synchronising");
    // R07: short low pulse does not drop link; a one frame minimum would qualify it
    chk_sync_filter: assert property (@(posedge pclk) disable iff (!presetn) // R07
        SYNC_MIN > 1 && link_up && !sync_n && $past(sync_n) && serializer_enable &&
        clk_ready |=> link_up)
        else $error("link dropped on one frame of sync low");
    // R14: bit 7 zero
    chk_status_b7: assert property (@(posedge pclk) disable iff (!presetn) // R14
        rd && hit_st |-> prdata[7] == 1'b0)
        else $error("status bit 7 not zero");
    // R01: step high byte write
    chk_step_write: assert property (@(posedge pclk) disable iff (!presetn) // R01
        wr && hit_hi |=> step_hi_reg == $past(pwdata[7:0]))
        else $error("step high byte not written");
    // R05: qualified request restarts sync
    chk_sync_restart: assert property (@(posedge pclk) disable iff (!presetn) // R05
        state_reg == SLRS_DATA && sync_req && serializer_enable && clk_ready
        |=> state_reg == SLRS_CGS)
        else $error("qualified request did not restart sync");
    // R04: full ila run before link
    chk_ila_length: assert property (@(posedge pclk) disable iff (!presetn) // R04
        $rose(link_up) |-> $past(cnt_reg) == 8'(ILA_LEN - 1))
        else $error("ila shorter than its length");
    // R13: ramp starts from zero
    chk_ramp_start: assert property (@(posedge pclk) disable iff (!presetn) // R13
        ramp_on && !$past(ramp_on) |-> ramp_reg == 16'h0000)
        else $error("ramp did not start at zero");
    // R07: unqualified low pin keeps flag high
    chk_sync_pin: assert property (@(posedge pclk) disable iff (!presetn) // R07
        state_reg == SLRS_DATA && !sync_n && !sync_req |-> status_val[`SLRS_ST_SYNC])
        else $error("sync flag followed the raw pin");

endmodule // slrs_top

`default_nettype wire

// File: core/slrs_cfg.svh
/*
 * slrs_cfg.svh: offsets, field positions, reset values and timing counts
 * for the serial link ramp and status block.
 * assumes: included by bare name; definitions only.
 */
`ifndef SLRS_CFG_SVH
`define SLRS_CFG_SVH

// register indices; byte address on the bus is index * 4
`define SLRS_IDX_RSTEP_LO 8'h62
`define SLRS_IDX_RSTEP_HI 8'h63
`define SLRS_IDX_STATUS 8'h6C
`define SLRS_IDX_CTRL 8'h70
`define SLRS_IDX_IRQ_STAT 8'h71
`define SLRS_IDX_IRQ_MASK 8'h72
`define SLRS_ADDR_W 10

// status field positions
`define SLRS_ST_LINK 6
`define SLRS_ST_SYNC 5
`define SLRS_ST_CLOCK_PHASE_SHIFT_FLAG 4

// control field positions
`define SLRS_CTRL_EN 0
`define SLRS_CTRL_TM_LSB 4

// reset values and the ramp test pattern code
`define SLRS_RST_STEP_LO 8'h01
`define SLRS_RST_STEP_HI 8'h00
`define SLRS_RST_CTRL 8'h00
`define SLRS_TM_RAMP 4'h6

// sync request qualification, in frame clock periods
`define SLRS_SYNC_MIN_FRAMES 4

// link bring-up: frame clocks of code group sync, then ila frames
`define SLRS_CGS_FRAMES 4
`define SLRS_ILA_FRAMES 16

`endif

// File: core/slrs_pkg.sv
/*
 * slrs_pkg.sv: types for the serial link ramp and status block.
 * assumes: compiled before the block.
 */
package slrs_pkg;
    // link bring-up sequence, gray coded along the usual path
    typedef enum logic [1:0] {
        SLRS_IDLE = 2'b00,
        SLRS_CGS = 2'b01,
        SLRS_ILA = 2'b11,
        SLRS_DATA = 2'b10
    } slrs_link_e;
endpackage

// File: testbench/slrs_rx_model.sv
/*
 * slrs_rx_model.sv: receiver side of the link, drives the sync request.
 * assumes: bench pulses req_go for one cycle with the low time in req_len.
 */
`timescale 1ns/1ps
`default_nettype none

module slrs_rx_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic req_go,
    input wire logic [7:0] req_len,
    output logic sync_n
);
    logic [7:0] low_reg;

    // low for the commanded frame count
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_reg <= 8'h00;
        end else if (req_go) begin
            low_reg <= req_len;
        end else if (low_reg != 8'h00) begin
            low_reg <= low_reg - 8'h01;
        end
    end

    // idle level is high: request released
    assign sync_n = (low_reg == 8'h00);
endmodule // slrs_rx_model

`default_nettype wire

// File: testbench/tb.sv
/*
 * tb.sv: self-checking bench for the ramp step and link status block.
 * assumes: apb slave answers by pready; receiver model drives sync_n.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
    localparam logic [9:0] A_LO = 10'h188, A_HI = 10'h18C, A_ST = 10'h1B0;
    localparam logic [9:0] A_CTL = 10'h1C0, A_IST = 10'h1C4, A_IMSK = 10'h1C8;
    localparam logic [9:0] A_BAD = 10'h1F0;
    localparam logic [15:0] STEP = 16'h8001;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, sync_n;
    logic sysref_shift, clk_ready, serializer_enable, sample_valid, irq, req_go;
    logic [9:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb, test_pattern_select;
    logic [15:0] sample_out;
    logic [7:0] req_len;
    logic er;
    int miscompares = 0;
    int n_checks = 0;

    slrs_top #(.SYNC_MIN(4), .CGS_LEN(2), .ILA_LEN(3)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sync_n(sync_n),
        .sysref_shift(sysref_shift), .clk_ready(clk_ready),
        .serializer_enable(serializer_enable), .test_pattern_select(test_pattern_select),
        .sample_out(sample_out), .sample_valid(sample_valid), .irq(irq));
    slrs_rx_model rx (.pclk(pclk), .presetn(presetn), .req_go(req_go), .req_len(req_len),
        .sync_n(sync_n));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // starts one edge later so a release is never overwritten in its own step
    task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 50) check(32'h0, 32'h1);
    endtask

    task automatic pulse_sysref();
        @(posedge pclk);
        sysref_shift <= 1'b1;
        @(posedge pclk);
        sysref_shift <= 1'b0;
        repeat (2) @(posedge pclk);
    endtask

    task automatic wait_link();
        int k;
        k = 0;
        do begin
            apb(1'b0, A_ST, 32'h0);
            k++;
        end while (rd[6] !== 1'b1 && k < 40);
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_regs();
        apb(1'b0, A_LO, 32'h0);
        check(rd, 32'h01);
        apb(1'b0, A_HI, 32'h0);
        check(rd, 32'h00);
        apb(1'b0, A_ST, 32'h0);
        check(rd, 32'h00);
        apb(1'b0, A_BAD, 32'h0);
        check({31'h0, er}, 32'h1);
        apb(1'b1, A_ST, 32'h80);
        apb(1'b0, A_ST, 32'h0);
        check(rd, 32'h00);
        // nonzero step, written while link disabled
        apb(1'b1, A_LO, {24'h0, STEP[7:0]});
        apb(1'b1, A_HI, {24'h0, STEP[15:8]});
        apb(1'b0, A_LO, 32'h0);
        check(rd, {24'h0, STEP[7:0]});
        apb(1'b0, A_HI, 32'h0);
        check(rd, {24'h0, STEP[15:8]});
        // write with byte lane 0 off leaves the step alone
        pstrb <= 4'hE;
        apb(1'b1, A_LO, 32'h0);
        pstrb <= 4'hF;
        apb(1'b0, A_LO, 32'h0);
        check(rd, {24'h0, STEP[7:0]});
        $display("test regs done");
    endtask

    task automatic t_link();
        logic [15:0] s;
        int k;
        @(posedge pclk);
        req_len <= 8'd30;
        req_go <= 1'b1;
        @(posedge pclk);
        req_go <= 1'b0;
        apb(1'b1, A_CTL, 32'h61);
        apb(1'b0, A_ST, 32'h0);
        check(rd, 32'h00);
        check({27'h0, test_pattern_select, serializer_enable}, 32'h0D);
        wait_link();
        check(rd, 32'h60);
        k = 0;
        while (sample_valid !== 1'b1 && k < 20) begin
            @(posedge pclk);
            k++;
        end
        check({31'h0, sample_valid}, 32'h1);
        // sampled on the falling edge, where the ramp register has settled
        @(negedge pclk);
        s = sample_out;
        repeat (6) begin
            @(negedge pclk);
            check({16'h0, sample_out}, {16'h0, s + STEP});
            s = sample_out;
        end
        $display("test link done");
    endtask

    task automatic t_resync();
        @(posedge pclk);
        req_len <= 8'd3;
        req_go <= 1'b1;
        @(posedge pclk);
        req_go <= 1'b0;
        repeat (5) @(posedge pclk);
        apb(1'b0, A_ST, 32'h0);
        check(rd, 32'h60);
        req_len <= 8'd12;
        req_go <= 1'b1;
        @(posedge pclk);
        req_go <= 1'b0;
        repeat (6) @(posedge pclk);
        apb(1'b0, A_ST, 32'h0);
        check(rd, 32'h00);
        wait_link();
        check(rd, 32'h60);
        $display("test resync done");
    endtask

    task automatic t_clock_phase_shift_flag();
        apb(1'b0, A_IST, 32'h0);
        check(rd, 32'h03);
        apb(1'b1, A_IMSK, 32'h04);
        pulse_sysref();
        check({31'h0, irq}, 32'h1);
        apb(1'b0, A_ST, 32'h0);
        check(rd, 32'h70);
        apb(1'b1, A_ST, 32'h00);
        apb(1'b0, A_ST, 32'h0);
        check(rd, 32'h70);
        apb(1'b1, A_ST, 32'h10);
        apb(1'b0, A_ST, 32'h0);
        check(rd, 32'h60);
        apb(1'b0, A_IST, 32'h0);
        check(rd, 32'h04);
        @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        // masked event must stay silent
        apb(1'b1, A_IMSK, 32'h00);
        pulse_sysref();
        check({31'h0, irq}, 32'h0);
        clk_ready <= 1'b0;
        repeat (2) @(posedge pclk);
        clk_ready <= 1'b1;
        apb(1'b0, A_ST, 32'h0);
        check(rd & 32'h50, 32'h00);
        $display("test clock_phase_shift_flag done");
    endtask

    task automatic t_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        @(negedge pclk);
        check({15'h0, sample_valid, sample_out}, 32'h0);
        check({27'h0, test_pattern_select, serializer_enable}, 32'h0);
        check({31'h0, irq}, 32'h0);
        apb(1'b0, A_LO, 32'h0);
        check(rd, 32'h01);
        apb(1'b0, A_ST, 32'h0);
        check(rd, 32'h00);
        $display("test reset done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("checks=%0d miscompares=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        conclude();
    end

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 10'h000;
        pwdata = 32'h0;
        pstrb = 4'hF;
        sysref_shift = 1'b0;
        clk_ready = 1'b1;
        req_go = 1'b0;
        req_len = 8'h00;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_link();
        t_resync();
        t_clock_phase_shift_flag();
        t_reset();
        conclude();
    end
endmodule // tb

`default_nettype wire
